// ==== mspc_regs.sv ====
// Purpose: spi protocol configuration and status registers with their gating logic
// Assumes: register port and frame strobes come from logic on clk_sys; chip select is a pin
// Notes:   read data is registered, one cycle after the read strobe
module mspc_regs (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        reg_wr_en,
   input  wire logic        reg_rd_en,
   input  wire logic [15:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata_ff,
   output logic             reg_rvalid_ff,
   input  wire logic        chip_select_n,
   input  wire logic        tx_frame_req,
   input  wire logic        rx_frame_req,
   output logic             tx_frame_accept_ff,
   output logic             rx_frame_accept_ff,
   input  wire logic        tx_byte_valid,
   input  wire logic [7:0]  tx_byte,
   input  wire logic        tx_frame_last,
   input  wire logic        tx_buf_has_data,
   input  wire logic        tx_buf_frame_whole,
   output logic             tx_line_start_ok_ff,
   input  wire logic        rx_buf_has_data,
   input  wire logic        rx_buf_frame_whole,
   output logic             rx_host_start_ok_ff,
   input  wire logic        rx_chunk_start,
   input  wire logic [3:0]  rx_word_pos,
   output logic             rx_frame_start_ok_ff,
   input  wire logic [5:0]  tx_credit_count,
   input  wire logic        tx_credit_seen,
   output logic             interrupt_line_n_ff,
   input  wire logic        ctrl_txn_done,
   input  wire logic        ctrl_txn_err,
   output logic             control_protection_enable_ff,
   output logic      [6:0]  chunk_payload_bytes_ff
);

   ////////////////////////////////////////////////////////////////////////////
   // decoding helpers

   function automatic logic [6:0] mspc_cps_bytes(input logic [2:0] code);
      unique case (code)
         mspc_pkg::CPS_8:  mspc_cps_bytes = 7'h08;
         mspc_pkg::CPS_16: mspc_cps_bytes = 7'h10;
         mspc_pkg::CPS_32: mspc_cps_bytes = 7'h20;
         mspc_pkg::CPS_64: mspc_cps_bytes = 7'h40;
         default:          mspc_cps_bytes = 7'h40;  // unsupported codes act as largest
      endcase
   endfunction : mspc_cps_bytes

   function automatic logic [5:0] mspc_thresh(input logic [1:0] code);
      unique case (code)
         2'h0: mspc_thresh = mspc_pkg::THR_CODE0;
         2'h1: mspc_thresh = mspc_pkg::THR_CODE1;
         2'h2: mspc_thresh = mspc_pkg::THR_CODE2;
         2'h3: mspc_thresh = mspc_pkg::THR_CODE3;
      endcase
   endfunction : mspc_thresh

   function automatic logic [31:0] mspc_crc_byte(input logic [31:0] crc, input logic [7:0] data);
      logic [31:0] c;
      c = crc ^ {24'h000000, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ mspc_pkg::CRC_POLY) : (c >> 1);
      end
      mspc_crc_byte = c;
   endfunction : mspc_crc_byte

   ////////////////////////////////////////////////////////////////////////////
   // configuration register

   logic       sync_done_ff;
   logic       txfcsv_en_ff;
   logic       csalign_en_ff;
   logic       zalign_en_ff;
   logic [1:0] thresh_ff;
   logic       txct_en_ff;
   logic       rxct_en_ff;
   logic       prot_en_ff;
   logic [2:0] cps_ff;
   logic       wr_cfg;
   logic       wr_sts;

   assign wr_cfg = reg_wr_en && (reg_addr == mspc_pkg::ADDR_PROTOCOL_CONFIG);
   assign wr_sts = reg_wr_en && (reg_addr == mspc_pkg::ADDR_PROTOCOL_STATUS);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync_done_ff <= 1'b0;
      end else if (wr_cfg && reg_wdata[mspc_pkg::CFG_SYNC_BIT]) begin
         sync_done_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txfcsv_en_ff  <= 1'b0;
         csalign_en_ff <= 1'b0;
         zalign_en_ff  <= 1'b0;
         thresh_ff     <= mspc_pkg::RST_THRESH;
         txct_en_ff    <= 1'b0;
         rxct_en_ff    <= 1'b0;
         prot_en_ff    <= 1'b0;
         cps_ff        <= mspc_pkg::RST_CPS;
      end else if (wr_cfg) begin
         // only writable fields are taken; bits 31:16, 7:6, 4:3 are dropped
         txfcsv_en_ff  <= reg_wdata[mspc_pkg::CFG_TXFCSV_BIT];
         csalign_en_ff <= reg_wdata[mspc_pkg::CFG_CSALIGN_BIT];
         zalign_en_ff  <= reg_wdata[mspc_pkg::CFG_ZALIGN_BIT];
         thresh_ff     <= reg_wdata[mspc_pkg::CFG_THRESH_LSB +: 2];
         txct_en_ff    <= reg_wdata[mspc_pkg::CFG_TXCT_BIT];
         rxct_en_ff    <= reg_wdata[mspc_pkg::CFG_RXCT_BIT];
         prot_en_ff    <= reg_wdata[mspc_pkg::CFG_PROT_BIT];
         cps_ff        <= reg_wdata[mspc_pkg::CFG_CPS_LSB +: 3];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         control_protection_enable_ff <= 1'b0;
         chunk_payload_bytes_ff       <= 7'h40;
      end else begin
         control_protection_enable_ff <= prot_en_ff;
         chunk_payload_bytes_ff       <= mspc_cps_bytes(cps_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame acceptance and cut-through

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_frame_accept_ff  <= 1'b0;
         rx_frame_accept_ff  <= 1'b0;
         tx_line_start_ok_ff <= 1'b0;
         rx_host_start_ok_ff <= 1'b0;
      end else begin
         tx_frame_accept_ff  <= tx_frame_req && sync_done_ff;
         rx_frame_accept_ff  <= rx_frame_req && sync_done_ff;
         // store and forward waits for the whole frame; cut-through for any data
         tx_line_start_ok_ff <= sync_done_ff && (txct_en_ff ? tx_buf_has_data : tx_buf_frame_whole);
         rx_host_start_ok_ff <= sync_done_ff && (rxct_en_ff ? rx_buf_has_data : rx_buf_frame_whole);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive start alignment

   logic       cs_meta_ff;
   logic       cs_sync_ff;
   logic       cs_prev_ff;
   logic       first_chunk_ff;
   logic       chunk_is_first_ff;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cs_meta_ff <= 1'b1;
         cs_sync_ff <= 1'b1;
         cs_prev_ff <= 1'b1;
      end else begin
         cs_meta_ff <= chip_select_n;
         cs_sync_ff <= cs_meta_ff;
         cs_prev_ff <= cs_sync_ff;
      end
   end

   // first_chunk_ff: armed at select assertion, spent by the next chunk start
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         first_chunk_ff    <= 1'b0;
         chunk_is_first_ff <= 1'b0;
      end else begin
         if (cs_prev_ff && !cs_sync_ff) begin
            first_chunk_ff <= 1'b1;
         end else if (rx_chunk_start) begin
            first_chunk_ff <= 1'b0;
         end
         if (rx_chunk_start) begin
            chunk_is_first_ff <= first_chunk_ff || (cs_prev_ff && !cs_sync_ff);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_frame_start_ok_ff <= 1'b0;
      end else if (csalign_en_ff) begin
         rx_frame_start_ok_ff <= chunk_is_first_ff && (rx_word_pos == 4'h0);
      end else if (zalign_en_ff) begin
         rx_frame_start_ok_ff <= (rx_word_pos == 4'h0);
      end else begin
         rx_frame_start_ok_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit credit interrupt

   logic credit_armed_ff;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         credit_armed_ff <= 1'b0;
      end else if (tx_credit_count == 6'h00) begin
         credit_armed_ff <= 1'b1;
      end else if (tx_credit_seen) begin
         credit_armed_ff <= 1'b0;
      end
   end

   // active low; held while credits are at or above the threshold, until the engine reports the host has seen the credits
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         interrupt_line_n_ff <= 1'b1;
      end else begin
         interrupt_line_n_ff <= !(credit_armed_ff && (tx_credit_count >= mspc_thresh(thresh_ff)));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit fcs validation

   mspc_pkg::mspc_fcs_t fcs_state_ff;
   logic [31:0]         crc_ff;
   logic [31:0]         crc_next;
   logic                fcs_bad_pulse_ff;

   assign crc_next = mspc_crc_byte((fcs_state_ff == mspc_pkg::MSPC_FCS_IDLE) ? mspc_pkg::CRC_INIT : crc_ff, tx_byte);

   // the residue test covers the trailing four octets together with the body
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fcs_state_ff     <= mspc_pkg::MSPC_FCS_IDLE;
         crc_ff           <= mspc_pkg::CRC_INIT;
         fcs_bad_pulse_ff <= 1'b0;
      end else begin
         fcs_bad_pulse_ff <= 1'b0;
         if (tx_byte_valid) begin
            crc_ff <= crc_next;
            if (tx_frame_last) begin
               fcs_state_ff     <= mspc_pkg::MSPC_FCS_IDLE;
               fcs_bad_pulse_ff <= txfcsv_en_ff && (crc_next != mspc_pkg::CRC_RESIDUE);
            end else begin
               fcs_state_ff <= mspc_pkg::MSPC_FCS_RUN;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags, write one to clear, a new event wins over the clear

   logic control_protection_error_ff;
   logic tx_checksum_error_ff;
   logic control_protection_error_set;

   assign control_protection_error_set = ctrl_txn_done && ctrl_txn_err && prot_en_ff;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         control_protection_error_ff <= 1'b0;
      end else if (control_protection_error_set) begin
         control_protection_error_ff <= 1'b1;
      end else if (wr_sts && reg_wdata[mspc_pkg::STS_CONTROL_PROTECTION_ERROR_BIT]) begin
         control_protection_error_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_checksum_error_ff <= 1'b0;
      end else if (fcs_bad_pulse_ff) begin
         tx_checksum_error_ff <= 1'b1;
      end else if (wr_sts && reg_wdata[mspc_pkg::STS_TX_CHECKSUM_ERROR_BIT]) begin
         tx_checksum_error_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path

   logic [31:0] cfg_view;
   logic [31:0] sts_view;

   always_comb begin
      cfg_view                               = 32'h00000000;
      cfg_view[mspc_pkg::CFG_SYNC_BIT]       = sync_done_ff;
      cfg_view[mspc_pkg::CFG_TXFCSV_BIT]     = txfcsv_en_ff;
      cfg_view[mspc_pkg::CFG_CSALIGN_BIT]    = csalign_en_ff;
      cfg_view[mspc_pkg::CFG_ZALIGN_BIT]     = zalign_en_ff;
      cfg_view[mspc_pkg::CFG_THRESH_LSB +: 2] = thresh_ff;
      cfg_view[mspc_pkg::CFG_TXCT_BIT]       = txct_en_ff;
      cfg_view[mspc_pkg::CFG_RXCT_BIT]       = rxct_en_ff;
      cfg_view[mspc_pkg::CFG_TSEN_BIT]       = 1'b0;
      cfg_view[mspc_pkg::CFG_TSSEL_BIT]      = 1'b0;
      cfg_view[mspc_pkg::CFG_PROT_BIT]       = prot_en_ff;
      cfg_view[mspc_pkg::CFG_CPS_LSB +: 3]   = cps_ff;
   end

   always_comb begin
      sts_view                           = 32'h00000000;
      sts_view[mspc_pkg::STS_CONTROL_PROTECTION_ERROR_BIT]   = control_protection_error_ff;
      sts_view[mspc_pkg::STS_TX_CHECKSUM_ERROR_BIT] = tx_checksum_error_ff;
      sts_view[mspc_pkg::STS_TSCAP_BIT]  = 1'b0;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata_ff  <= 32'h00000000;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= reg_rd_en;
         if (reg_rd_en) begin
            if (reg_addr == mspc_pkg::ADDR_PROTOCOL_CONFIG) begin
               reg_rdata_ff <= cfg_view;
            end else if (reg_addr == mspc_pkg::ADDR_PROTOCOL_STATUS) begin
               reg_rdata_ff <= sts_view;
            end else begin
               reg_rdata_ff <= 32'h00000000;  // unmapped reads as zero
            end
         end
      end
   end

endmodule : mspc_regs

// ==== mspc_pkg.sv ====
// Purpose: constants for the spi protocol configuration and status bank
// Assumes: word-addressed register port from the spi control engine
// Notes:   offsets are the control-transaction addresses in memory map zero
package mspc_pkg;
   localparam logic [15:0] ADDR_PROTOCOL_CONFIG = 16'h0004;
   localparam logic [15:0] ADDR_PROTOCOL_STATUS = 16'h0008;

   // spi_protocol_config fields
   localparam int CFG_SYNC_BIT     = 15;
   localparam int CFG_TXFCSV_BIT   = 14;
   localparam int CFG_CSALIGN_BIT  = 13;
   localparam int CFG_ZALIGN_BIT   = 12;
   localparam int CFG_THRESH_LSB   = 10;
   localparam int CFG_TXCT_BIT     = 9;
   localparam int CFG_RXCT_BIT     = 8;
   localparam int CFG_TSEN_BIT     = 7;
   localparam int CFG_TSSEL_BIT    = 6;
   localparam int CFG_PROT_BIT     = 5;
   localparam int CFG_CPS_LSB      = 0;

   // spi_protocol_status fields
   localparam int STS_CONTROL_PROTECTION_ERROR_BIT     = 12;
   localparam int STS_TX_CHECKSUM_ERROR_BIT   = 11;
   localparam int STS_TSCAP_BIT    = 10;

   // reset values
   localparam logic [1:0] RST_THRESH = 2'h0;
   localparam logic [2:0] RST_CPS    = 3'h6;

   // chunk payload size codes
   localparam logic [2:0] CPS_8  = 3'h3;
   localparam logic [2:0] CPS_16 = 3'h4;
   localparam logic [2:0] CPS_32 = 3'h5;
   localparam logic [2:0] CPS_64 = 3'h6;

   // credit thresholds
   localparam logic [5:0] THR_CODE0 = 6'h01;
   localparam logic [5:0] THR_CODE1 = 6'h04;
   localparam logic [5:0] THR_CODE2 = 6'h08;
   localparam logic [5:0] THR_CODE3 = 6'h10;

   // ethernet fcs checking, reflected crc32
   localparam logic [31:0] CRC_POLY    = 32'hedb88320;
   localparam logic [31:0] CRC_INIT    = 32'hffffffff;
   localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

   typedef enum logic [1:0] {
      MSPC_FCS_IDLE,
      MSPC_FCS_RUN
   } mspc_fcs_t;
endpackage : mspc_pkg

// ==== mspc_regs_chk.sv ====
// Purpose: port-level assertions for mspc_regs
// Assumes: one clk_sys domain, async rst
// Notes:   shadow flags follow host writes only
module mspc_regs_chk (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        reg_wr_en,
   input wire logic        reg_rd_en,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata_ff,
   input wire logic        reg_rvalid_ff,
   input wire logic        tx_frame_req,
   input wire logic        rx_frame_req,
   input wire logic        tx_frame_accept_ff,
   input wire logic        rx_frame_accept_ff,
   input wire logic [5:0]  tx_credit_count,
   input wire logic        interrupt_line_n_ff,
   input wire logic        control_protection_enable_ff,
   input wire logic [6:0]  chunk_payload_bytes_ff
);
   wire logic  wr_cfg = reg_wr_en && reg_addr == mspc_pkg::ADDR_PROTOCOL_CONFIG;
   wire logic  rd_cfg = reg_rd_en && reg_addr == mspc_pkg::ADDR_PROTOCOL_CONFIG;
   wire logic  rd_sts = reg_rd_en && reg_addr == mspc_pkg::ADDR_PROTOCOL_STATUS;
   logic       sync_ff;
   logic [1:0] thr_ff;
   logic [5:0] thr_n;
   assign thr_n = (thr_ff == 2'h0) ? 6'h01 : 6'h04 << (thr_ff - 2'h1);
   // shadow of the sticky flag: a write of zero must not drop it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync_ff <= 1'b0;
         thr_ff  <= 2'h0;
      end else if (wr_cfg) begin
         sync_ff <= sync_ff | reg_wdata[15];
         thr_ff  <= reg_wdata[11:10];
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   property p_txacc;
      tx_frame_accept_ff == ($past(tx_frame_req) && $past(sync_ff));
   endproperty
   a_txacc: assert property (p_txacc)
      else $error("tx accept wrong");
   property p_rxacc;
      rx_frame_accept_ff == ($past(rx_frame_req) && $past(sync_ff));
   endproperty
   a_rxacc: assert property (p_rxacc)
      else $error("rx accept wrong");
   property p_sync;
      rd_cfg |=> reg_rdata_ff[15] == $past(sync_ff);
   endproperty
   a_sync: assert property (p_sync)
      else $error("sync flag wrong");
   property p_rocfg;
      rd_cfg |=> reg_rdata_ff[31:16] == 16'h0000 && reg_rdata_ff[7:6] == 2'h0 && reg_rdata_ff[4:3] == 2'h0;
   endproperty
   a_rocfg: assert property (p_rocfg)
      else $error("config fixed bits nonzero");
   property p_rosts;
      rd_sts |=> reg_rdata_ff[10] == 1'b0 && reg_rdata_ff[31:13] == 19'h00000;
   endproperty
   a_rosts: assert property (p_rosts)
      else $error("status fixed bits nonzero");
   property p_unmap;
      reg_rd_en && !rd_cfg && !rd_sts |=> reg_rvalid_ff && reg_rdata_ff == 32'h00000000;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read nonzero");
   property p_prot;
      wr_cfg |-> ##2 control_protection_enable_ff == $past(reg_wdata[5], 2);
   endproperty
   a_prot: assert property (p_prot)
      else $error("protection enable wrong");
   property p_cps;
      wr_cfg && reg_wdata[2:0] == 3'h3 |-> ##[1:2] chunk_payload_bytes_ff == 7'h08;
   endproperty
   a_cps: assert property (p_cps)
      else $error("payload size wrong");
   property p_irq;
      $fell(interrupt_line_n_ff) |-> $past(tx_credit_count) >= $past(thr_n);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt below threshold");
endmodule : mspc_regs_chk

bind mspc_regs mspc_regs_chk i_mspc_regs_chk (.*);

// ==== mspc_host.sv ====
// Purpose: host model, chip select and host frame bytes
// Assumes: bytes handed over on clk_sys
// Notes:   fcs made here, reflected crc32
module mspc_host (
   input  wire logic       clk_sys,
   output logic            chip_select_n,
   output logic            tx_byte_valid,
   output logic      [7:0] tx_byte,
   output logic            tx_frame_last
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      chip_select_n = 1'b1;
      tx_byte_valid = 1'b0;
      tx_byte       = 8'h00;
      tx_frame_last = 1'b0;
   end
   // pin moves just after an edge, the synchroniser still sees it as foreign
   task automatic cs(input logic v);
      @(posedge clk_sys) #1;
      chip_select_n = v;
   endtask : cs
   // host appends its own fcs, mac append kept off
   task automatic send(input logic bad);
      logic [31:0] c;
      logic [7:0]  b;
      c = 32'hffffffff;
      for (int i = 0; i < 8; i++) begin
         b = (i < 4) ? 8'(8'h5a + i) : 8'(~c >> (8 * (i - 4)));
         if (i == 7 && bad) b = ~b;
         @(posedge clk_sys) #1;
         tx_byte_valid = 1'b1;
         tx_byte       = b;
         tx_frame_last = (i == 7);
         if (i < 4) begin
            c = c ^ 32'(b);
            repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
         end
      end
      @(posedge clk_sys) #1;
      tx_byte_valid = 1'b0;
      tx_frame_last = 1'b0;
      tx_byte       = ~tx_byte;
   endtask : send
endmodule : mspc_host

// ==== mspc_regs_bench.sv ====
// Purpose: self-checking bench for mspc_regs
// Assumes: inputs move 1 ns after the rising edge
// Notes:   run is under two hundred cycles
module mspc_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_sys, rst, reg_wr_en, reg_rd_en, reg_rvalid_ff;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata_ff;
   logic        chip_select_n, tx_frame_req, rx_frame_req, tx_frame_accept_ff, rx_frame_accept_ff;
   logic        tx_byte_valid, tx_frame_last, tx_buf_has_data, tx_buf_frame_whole, tx_line_start_ok_ff;
   logic        rx_buf_has_data, rx_buf_frame_whole, rx_host_start_ok_ff, rx_chunk_start, rx_frame_start_ok_ff;
   logic        tx_credit_seen, interrupt_line_n_ff, ctrl_txn_done, ctrl_txn_err, control_protection_enable_ff;
   logic [7:0]  tx_byte;
   logic [3:0]  rx_word_pos;
   logic [5:0]  tx_credit_count;
   logic [6:0]  chunk_payload_bytes_ff;
   logic [5:0]  thr [4] = '{6'h01, 6'h04, 6'h08, 6'h10};
   int          errors, num_checks, cyc;
   mspc_regs i_mspc_regs (.*);
   mspc_host i_mspc_host (.*);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      step(1);
      reg_wr_en = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      step(1);
      reg_wr_en = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      step(1);
      reg_rd_en = 1'b1;
      reg_addr  = a;
      step(1);
      reg_rd_en = 1'b0;
      chk("rvalid", 32'(reg_rvalid_ff), 32'h1);
      chk("rdata", reg_rdata_ff, e);
   endtask : rd
   task automatic chunk(input logic [3:0] p, input logic e);
      step(1);
      rx_chunk_start = 1'b1;
      rx_word_pos    = p;
      step(1);
      rx_chunk_start = 1'b0;
      // first-chunk mark is registered before the start verdict, two edges in all
      step(1);
      chk("start_ok", 32'(rx_frame_start_ok_ff), 32'(e));
   endtask : chunk
   task automatic bufs(input logic [3:0] v, input logic [1:0] e);
      {tx_buf_has_data, tx_buf_frame_whole, rx_buf_has_data, rx_buf_frame_whole} = v;
      step(2);
      chk("start_gate", 32'({tx_line_start_ok_ff, rx_host_start_ok_ff}), 32'(e));
   endtask : bufs
   // hang guard, far above the expected run
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      {rst, reg_wr_en, reg_rd_en, tx_frame_req, rx_frame_req, tx_buf_has_data, tx_buf_frame_whole} = 7'h40;
      {rx_buf_has_data, rx_buf_frame_whole, rx_chunk_start, tx_credit_seen, ctrl_txn_done, ctrl_txn_err} = 6'h00;
      reg_addr        = 16'h0000;
      reg_wdata       = 32'h00000000;
      rx_word_pos     = 4'h0;
      tx_credit_count = 6'h00;
      step(6);
      rst = 1'b0;
      rd(16'h0004, 32'h00000006);
      rd(16'h0008, 32'h00000000);
      rd(16'h000c, 32'h00000000);
      chk("irq_n", 32'(interrupt_line_n_ff), 32'h1);
      chk("cps", 32'(chunk_payload_bytes_ff), 32'h40);
      tx_frame_req = 1'b1;
      rx_frame_req = 1'b1;
      step(2);
      chk("accept", 32'({tx_frame_accept_ff, rx_frame_accept_ff}), 32'h0);
      $display("test reset done");
      wr(16'h0004, 32'hfffffffd);
      step(1);
      chk("accept", 32'({tx_frame_accept_ff, rx_frame_accept_ff}), 32'h3);
      rd(16'h0004, 32'h0000ff25);
      chk("cps", 32'(chunk_payload_bytes_ff), 32'h20);
      chk("prot", 32'(control_protection_enable_ff), 32'h1);
      bufs(4'b1010, 2'b11);
      i_mspc_host.cs(1'b0);
      step(6);
      chunk(4'h0, 1'b1);
      chunk(4'h0, 1'b0);
      i_mspc_host.cs(1'b1);
      wr(16'h0004, 32'h00001006);
      rd(16'h0004, 32'h00009006);
      chunk(4'h3, 1'b0);
      chunk(4'h0, 1'b1);
      bufs(4'b1010, 2'b00);
      bufs(4'b0101, 2'b11);
      wr(16'h0004, 32'h00000006);
      chunk(4'h3, 1'b1);
      $display("test config done");
      wr(16'h0004, 32'h00004026);
      i_mspc_host.send(1'b0);
      step(3);
      rd(16'h0008, 32'h00000000);
      i_mspc_host.send(1'b1);
      step(3);
      rd(16'h0008, 32'h00000800);
      wr(16'h0008, 32'h00000000);
      rd(16'h0008, 32'h00000800);
      wr(16'h0008, 32'h00000800);
      rd(16'h0008, 32'h00000000);
      ctrl_txn_done = 1'b1;
      ctrl_txn_err  = 1'b1;
      step(1);
      ctrl_txn_done = 1'b0;
      ctrl_txn_err  = 1'b0;
      rd(16'h0008, 32'h00001000);
      wr(16'h0008, 32'h00001000);
      rd(16'h0008, 32'h00000000);
      $display("test status done");
      // credits drop to zero first so the interrupt is armed
      for (int c = 0; c < 4; c++) begin
         wr(16'h0004, 32'h00008003 | (32'(c) << 10));
         step(3);
         tx_credit_count = thr[c] - 6'h01;
         step(3);
         chk("irq_n", 32'(interrupt_line_n_ff), 32'h1);
         tx_credit_count = thr[c];
         step(3);
         chk("irq_n", 32'(interrupt_line_n_ff), 32'h0);
         tx_credit_seen = 1'b1;
         step(1);
         tx_credit_seen = 1'b0;
         step(3);
         chk("irq_n", 32'(interrupt_line_n_ff), 32'h1);
         tx_credit_count = 6'h00;
      end
      chk("cps", 32'(chunk_payload_bytes_ff), 32'h08);
      // protection and validation are both off now: neither flag may set
      ctrl_txn_done = 1'b1;
      ctrl_txn_err  = 1'b1;
      step(1);
      ctrl_txn_done = 1'b0;
      ctrl_txn_err  = 1'b0;
      i_mspc_host.send(1'b1);
      step(3);
      rd(16'h0008, 32'h00000000);
      $display("test credit done");
      final_report();
   end
endmodule : mspc_regs_bench
